// File: rtl/accel_dsp_filter_chain.sv
// Accelerometer signal chain: sinc decimator, low-pass, offset cancel, interpolator, scaler.
`timescale 1ns/10ps
// Functional notes
// - Third-order sinc, length and decimation sixteen, divided by sixteen per stage.
// - Each decimated sample passes gain, first-order then second-order low-pass.
// - Low-pass sections use the fixed printed coefficients.
// - First-order offset estimate is subtracted from the path, giving a high-pass.
// - Offset filter has 10 Hz, 0.3 Hz and 0.1 Hz coefficient sets.
// - Startup runs 10 Hz for 80 ms, then 0.3 Hz for 70 ms, unlimited.
// - Self-test uses 0.3 Hz, no rate limit, 96 ms per sequence, selftest_repeats sequences (at least one, at most six).
// - Offset output is frozen during the initialization self-test.
// - Once initialization is done drift_filter_select picks the normal set, 0.1 Hz when set, else 0.3 Hz, limited.
// - Normal operation moves the offset output by a step per interval at most.
// - Monitor compares offset estimate against upper and lower limits every sample.
// - Monitor counter counts up outside the limits and down inside them.
// - Counter above its limit clears zero_drift_ok_flag.
// - Monitor counter saturates at its maximum and never wraps.
// - Monitor is idle during initialization phases one, two and three.
// - Sixteen-to-one linear interpolation, results delayed one sample.
// - The 26-bit result is clipped and reduced to ten bits.
// - Output word is bits 21 down to 12, rounded from lower bits.
// - Datapath saturates instead of wrapping for any over-range input.
// - zero_drift_ok_flag is 0 after an offset error, else 1.
module accel_dsp_filter_chain #(
  parameter int          CNT_W               = 8,
  parameter int          DRIFT_COUNT_LIMIT   = 100,
  parameter int          DRIFT_COUNT_MAX     = 255,
  parameter int          RATE_LIMIT_STEP     = 1,
  parameter int          RATE_LIMIT_INTERVAL = 64,
  parameter int unsigned PH1_LEN             = accel_dsp_pkg::PH1_SAMPLES,
  parameter int unsigned PH2_LEN             = accel_dsp_pkg::PH2_SAMPLES,
  parameter int unsigned ST_LEN              = accel_dsp_pkg::ST_SAMPLES
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        sd_bit,
  input  wire logic        sd_bit_valid,
  input  wire logic        drift_filter_select,
  input  wire logic        selftest_start,
  input  wire logic [2:0]  selftest_repeats,
  input  wire logic        init_done,
  input  wire logic [25:0] drift_upper_limit,
  input  wire logic [25:0] drift_lower_limit,
  output logic      [9:0]  accel_word,
  output logic             accel_valid,
  output logic             zero_drift_ok_flag,
  output logic      [2:0]  init_phase
);
  localparam int W  = accel_dsp_pkg::DATA_W;
  localparam int CF = accel_dsp_pkg::CF;
  localparam logic signed [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};

  function automatic logic signed [W-1:0] sat(input logic signed [63:0] v);
    if (v > 64'(SMAX)) begin
      sat = SMAX;
    end else if (v < 64'(SMIN)) begin
      sat = SMIN;
    end else begin
      sat = v[W-1:0];
    end
  endfunction

  function automatic logic signed [63:0] mulc(input logic signed [W-1:0] x,
                                              input logic signed [31:0] c);
    logic signed [63:0] p;
    p    = 64'(x) * 64'(c);
    mulc = p >>> CF;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] rs_q;
  logic       rst_n;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rs_q <= 2'b00;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // sinc cubed decimator.
  logic signed [15:0] i1_q, i2_q, i3_q, c1_q, c2_q, c3_q;
  logic signed [15:0] c1_d, c2_d, c3_d, x_in;
  logic [3:0]         ph_q;
  logic               dec_stb_q;
  logic signed [W-1:0] dec_q;
  assign x_in = sd_bit ? 16'sh0001 : -16'sh0001;
  assign c1_d = i3_q - c1_q;
  assign c2_d = c1_d - c2_q;
  assign c3_d = c2_d - c3_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {i1_q, i2_q, i3_q, c1_q, c2_q, c3_q} <= '0;
      ph_q <= '0; dec_stb_q <= 1'b0; dec_q <= '0;
    end else begin
      dec_stb_q <= 1'b0;
      // one modulator bit per valid strobe.
      if (sd_bit_valid) begin
        i1_q <= i1_q + x_in;
        i2_q <= i2_q + i1_q + x_in;
        i3_q <= i3_q + i2_q + i1_q + x_in;
        ph_q <= ph_q + 4'h1;
        if (ph_q == 4'hf) begin
          c1_q <= i3_q; c2_q <= c1_d; c3_q <= c2_d;
          // Gain 16^3 is removed, then scaled to full 2^22, one bit above the output MSB position.
          dec_q <= W'(c3_d) <<< (accel_dsp_pkg::OUT_MSB + 1 - 3 * accel_dsp_pkg::DEC_LOG2);
          dec_stb_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gain, first-order and second-order low-pass sections.
  logic signed [W-1:0] g_d, s1_d, s2_d, s1_q, x1_q, y1_q, y2_q, s1p_q;
  logic                lp_stb_q;
  assign g_d  = sat(mulc(dec_q, accel_dsp_pkg::LP_A0) <<< 4);
  assign s1_d = sat((mulc(g_d, accel_dsp_pkg::LP_N11) + mulc(x1_q, accel_dsp_pkg::LP_N12)
                    - mulc(s1_q, accel_dsp_pkg::LP_D12)) <<< 0);
  assign s2_d = sat(mulc(s1_d, accel_dsp_pkg::LP_N21) + mulc(s1_q, accel_dsp_pkg::LP_N22)
                    + mulc(s1p_q, accel_dsp_pkg::LP_N23)
                    - mulc(y1_q, accel_dsp_pkg::LP_D22) - mulc(y2_q, accel_dsp_pkg::LP_D23));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {s1_q, x1_q, y1_q, y2_q, s1p_q} <= '0;
      lp_stb_q <= 1'b0;
    end else begin
      lp_stb_q <= dec_stb_q;
      if (dec_stb_q) begin
        x1_q <= g_d; s1p_q <= s1_q; s1_q <= s1_d; y2_q <= y1_q; y1_q <= s2_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Startup phase sequencer, counted in samples.
  accel_dsp_pkg::phase_t phase_q;
  logic [15:0] ph_cnt_q;
  logic [2:0]  st_rep_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= accel_dsp_pkg::PH_ONE; ph_cnt_q <= '0; st_rep_q <= '0;
    end else if (lp_stb_q) begin
      ph_cnt_q <= ph_cnt_q + 16'h1;
      case (phase_q)
        accel_dsp_pkg::PH_ONE: if (ph_cnt_q == 16'(PH1_LEN - 1)) begin
          phase_q <= accel_dsp_pkg::PH_TWO; ph_cnt_q <= '0;
        end
        accel_dsp_pkg::PH_TWO: if (ph_cnt_q >= 16'(PH2_LEN - 1)) begin
          phase_q  <= selftest_start ? accel_dsp_pkg::PH_SELFTEST : accel_dsp_pkg::PH_THREE;
          ph_cnt_q <= '0;
        end
        // 96 ms per sequence, at most six repeats.
        accel_dsp_pkg::PH_SELFTEST: if (ph_cnt_q == 16'(ST_LEN - 1)) begin
          ph_cnt_q <= '0; st_rep_q <= st_rep_q + 3'h1;
          if (st_rep_q + 3'h1 >= selftest_repeats || st_rep_q == 3'(accel_dsp_pkg::ST_MAX_REP - 1)) begin
            phase_q <= accel_dsp_pkg::PH_THREE;
          end
        end
        accel_dsp_pkg::PH_THREE: if (init_done) phase_q <= accel_dsp_pkg::PH_DONE;
        accel_dsp_pkg::PH_DONE:  phase_q <= accel_dsp_pkg::PH_DONE;
        default: phase_q <= accel_dsp_pkg::PH_ONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // coefficient set selection.
  logic signed [31:0] oc_g, oc_d;
  logic               done_ph, freeze, limit_on;
  assign done_ph = (phase_q == accel_dsp_pkg::PH_DONE);
  // drift_filter_select picks the normal set, 0.1 Hz when set, else 0.3 Hz.
  assign oc_g = (phase_q == accel_dsp_pkg::PH_ONE) ? accel_dsp_pkg::OC_G_10 :
                (done_ph && drift_filter_select) ? accel_dsp_pkg::OC_G_01 :
                accel_dsp_pkg::OC_G_03;
  assign oc_d = (phase_q == accel_dsp_pkg::PH_ONE) ? accel_dsp_pkg::OC_D_10 :
                (done_ph && drift_filter_select) ? accel_dsp_pkg::OC_D_01 :
                accel_dsp_pkg::OC_D_03;
  assign freeze   = (phase_q == accel_dsp_pkg::PH_SELFTEST);
  assign limit_on = done_ph;

  // first-order estimate of offset, subtracted from the path.
  logic signed [W-1:0] est_q, xo_q, oc_out_q, hp_q, est_d;
  logic [15:0]         rl_cnt_q;
  logic                hp_stb_q;
  assign est_d = sat(mulc(sat(mulc(y1_q, oc_g) <<< 0), accel_dsp_pkg::OC_N)
                 + mulc(sat(mulc(xo_q, oc_g)), accel_dsp_pkg::OC_N)
                 - mulc(est_q, oc_d));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      est_q <= '0; xo_q <= '0; oc_out_q <= '0; hp_q <= '0; rl_cnt_q <= '0; hp_stb_q <= 1'b0;
    end else begin
      hp_stb_q <= lp_stb_q;
      if (lp_stb_q) begin
        xo_q  <= y1_q;
        est_q <= est_d;
        rl_cnt_q <= (rl_cnt_q == 16'(RATE_LIMIT_INTERVAL - 1)) ? '0 : rl_cnt_q + 16'h1;
        if (!freeze) begin
          if (!limit_on) begin
            oc_out_q <= est_d;
          end else if (rl_cnt_q == '0) begin
            if (est_d > oc_out_q + W'(RATE_LIMIT_STEP)) begin
              oc_out_q <= oc_out_q + W'(RATE_LIMIT_STEP);
            end else if (est_d < oc_out_q - W'(RATE_LIMIT_STEP)) begin
              oc_out_q <= oc_out_q - W'(RATE_LIMIT_STEP);
            end else begin
              oc_out_q <= est_d;
            end
          end
        end
        hp_q <= sat(64'(y1_q) - 64'(oc_out_q));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // offset monitor, parameters.
  logic [CNT_W-1:0] mon_q;
  logic             outside;
  assign outside = ($signed(est_q) > $signed(drift_upper_limit)) ||
                   ($signed(est_q) < $signed(drift_lower_limit));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mon_q <= '0; zero_drift_ok_flag <= 1'b1;
    // only active once initialization is finished.
    end else if (hp_stb_q && done_ph) begin
      if (outside && mon_q != CNT_W'(DRIFT_COUNT_MAX)) begin
        mon_q <= mon_q + 1'b1;
      end else if (!outside && mon_q != '0) begin
        mon_q <= mon_q - 1'b1;
      end
      // flag cleared past the limit; sticky 0 means error.
      if (mon_q > CNT_W'(DRIFT_COUNT_LIMIT)) begin
        zero_drift_ok_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO decouples the sample producer from the interpolator.
  logic [W-1:0] f_data;
  logic         f_valid, f_ready, f_in_ready;
  sample_fifo #(.WIDTH(W), .DEPTH(8)) u_fifo (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .in_data   (hp_q),
    .in_valid  (hp_stb_q),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // interpolate prev to cur in sixteen steps, one sample late.
  logic signed [W-1:0] prev_q, cur_q, acc_q;
  logic [4:0]          step_q;
  logic [4:0]          tick_q;
  logic signed [W-1:0] delta;
  assign delta   = sat((64'(cur_q) - 64'(prev_q)) >>> accel_dsp_pkg::INT_LOG2);
  // Reloading on the last step keeps one word per bit period.
  // Waiting for step zero would lose a period per sample and overrun the FIFO.
  assign f_ready = (tick_q == '0) && (step_q <= 5'h1);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0; cur_q <= '0; acc_q <= '0; step_q <= '0; tick_q <= '0;
      accel_word <= '0; accel_valid <= 1'b0; init_phase <= '0;
    end else begin
      init_phase  <= 3'(phase_q);
      accel_valid <= 1'b0;
      tick_q <= (tick_q == 5'(accel_dsp_pkg::CLK_PER_BIT - 1)) ? '0 : tick_q + 5'h1;
      if (tick_q == '0 && step_q != '0) begin
        // clip to 10 bits; bits 21..12 rounded; saturate.
        accel_word  <= round_clip(acc_q);
        accel_valid <= 1'b1;
      end
      if (f_valid && f_ready) begin
        prev_q <= cur_q; cur_q <= f_data; acc_q <= cur_q; step_q <= 5'(accel_dsp_pkg::INT_RATIO);
      end else if (tick_q == '0 && step_q != '0) begin
        acc_q  <= sat(64'(acc_q) + 64'(delta));
        step_q <= step_q - 5'h1;
      end
    end
  end

  // Codes beyond the acceleration span carry status meanings, so clipping stops at the span.
  function automatic logic [9:0] round_clip(input logic signed [W-1:0] v);
    logic signed [W:0] r;
    logic signed [W:0] q;
    r = {v[W-1], v} + (W+1)'(1 << (accel_dsp_pkg::OUT_LSB - 1));
    q = r >>> accel_dsp_pkg::OUT_LSB;
    if (q > (W+1)'(accel_dsp_pkg::OUT_CODE_MAX)) begin
      round_clip = 10'(accel_dsp_pkg::OUT_CODE_MAX);
    end else if (q < -((W+1)'(accel_dsp_pkg::OUT_CODE_MAX))) begin
      round_clip = 10'(-accel_dsp_pkg::OUT_CODE_MAX);
    end else begin
      round_clip = q[accel_dsp_pkg::OUT_MSB-accel_dsp_pkg::OUT_LSB:0];
    end
  endfunction
endmodule

// File: common/accel_dsp_pkg.sv
// Constants shared by the accelerometer filter chain.
package accel_dsp_pkg;
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned BIT_RATE_HZ = 1000000;
  localparam int unsigned DEC_RATIO   = 16;
  localparam int unsigned DEC_LOG2    = 4;
  localparam int unsigned INT_RATIO   = 16;
  localparam int unsigned INT_LOG2    = 4;
  localparam int unsigned DATA_W      = 26;
  localparam int unsigned OUT_W       = 10;
  localparam int unsigned OUT_MSB     = 21;
  localparam int unsigned OUT_LSB     = 12;
  // Largest acceleration code; the codes above it carry status meanings.
  localparam int          OUT_CODE_MAX = 480;
  localparam int unsigned SAMPLE_US   = 16;
  // Coefficients in Q2.24 fixed point (scale 2^24).
  localparam int unsigned CF          = 24;
  localparam logic signed [31:0] LP_A0   = 32'sd870602;
  localparam logic signed [31:0] LP_N11  = 32'sd27331;
  localparam logic signed [31:0] LP_N12  = 32'sd27353;
  localparam logic signed [31:0] LP_D12  = -32'sd15906678;
  localparam logic signed [31:0] LP_N21  = 32'sd4195942;
  localparam logic signed [31:0] LP_N22  = 32'sd8388607;
  localparam logic signed [31:0] LP_N23  = 32'sd4192665;
  localparam logic signed [31:0] LP_D22  = -32'sd32142456;
  localparam logic signed [31:0] LP_D23  = 32'sd15419786;
  localparam logic signed [31:0] OC_G_10 = 32'sd267712;
  localparam logic signed [31:0] OC_G_03 = 32'sd8093;
  localparam logic signed [31:0] OC_G_01 = 32'sd2698;
  localparam logic signed [31:0] OC_D_10 = -32'sd16509504;
  localparam logic signed [31:0] OC_D_03 = -32'sd16769123;
  localparam logic signed [31:0] OC_D_01 = -32'sd16774517;
  localparam logic signed [31:0] OC_N    = 32'sd8388577;
  // Phase lengths.
  localparam int unsigned PH1_MS      = 80;
  localparam int unsigned PH2_MS      = 70;
  localparam int unsigned ST_SEQ_MS   = 96;
  localparam int unsigned ST_MAX_REP  = 6;
  localparam int unsigned PH1_SAMPLES = PH1_MS * 1000 / SAMPLE_US;
  localparam int unsigned PH2_SAMPLES = PH2_MS * 1000 / SAMPLE_US;
  localparam int unsigned ST_SAMPLES  = ST_SEQ_MS * 1000 / SAMPLE_US;
  localparam int unsigned CLK_PER_BIT = CLK_HZ / BIT_RATE_HZ;
  typedef enum logic [2:0] {PH_ONE, PH_TWO, PH_SELFTEST, PH_THREE, PH_DONE} phase_t;
  typedef enum logic [1:0] {SET_10HZ, SET_03HZ, SET_01HZ} oc_set_t;
endpackage

// File: rtl/sample_fifo.sv
// Small valid/ready FIFO for processed samples.
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic [AW:0]      used;
  logic             push;
  logic             pop;
  assign used      = wr_q - rd_q;
  assign in_ready  = (used != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q      <= '0;
      rd_q      <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      // Read data come out of a register; a word is loaded when the slot is free.
      if ((!out_valid || out_ready) && (wr_q != rd_q)) begin
        out_data  <= mem_q[rd_q[AW-1:0]];
        out_valid <= 1'b1;
        rd_q      <= rd_q + 1'b1;
      end else if (pop) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// File: test/accel_dsp_filter_chain_props.sv
// Concurrent port checks for the accelerometer filter chain.
`timescale 1ns/10ps
module accel_dsp_filter_chain_props (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        sd_bit,
  input wire logic        sd_bit_valid,
  input wire logic        drift_filter_select,
  input wire logic        selftest_start,
  input wire logic [2:0]  selftest_repeats,
  input wire logic        init_done,
  input wire logic [25:0] drift_upper_limit,
  input wire logic [25:0] drift_lower_limit,
  input wire logic [9:0]  accel_word,
  input wire logic        accel_valid,
  input wire logic        zero_drift_ok_flag,
  input wire logic [2:0]  init_phase
);
  logic        [9:0]  last_q;
  logic               seen_q;
  logic signed [10:0] step;
  // A wrapped datapath shows up as a jump of nearly the full code span between words.
  assign step = $signed({accel_word[9], accel_word}) - $signed({last_q[9], last_q});
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      last_q <= 10'h000;
      seen_q <= 1'b0;
    end else if (accel_valid) begin
      last_q <= accel_word;
      seen_q <= 1'b1;
    end
  end
  sequence s_word_out;
    accel_valid;
  endsequence
  sequence s_quiet;
    !accel_valid [*8];
  endsequence
  a_valid_single_pulse: assert property (s_word_out |=> s_quiet)
    else $error("accel_valid pulses too close together");
  a_valid_steady_cadence: assert property (s_word_out |-> ##[1:40] s_word_out)
    else $error("interpolated words stopped arriving");
  a_word_held: assert property ($changed(accel_word) |-> accel_valid)
    else $error("accel_word changed without accel_valid");
  a_flag_sticky: assert property (!zero_drift_ok_flag |=> !zero_drift_ok_flag)
    else $error("offset error flag set again before reset");
  a_flag_done_only: assert property ($fell(zero_drift_ok_flag) |-> init_phase == 3'h4)
    else $error("offset error flagged during initialization");
  a_phase_order: assert property ($changed(init_phase) |->
      (init_phase == $past(init_phase) + 3'h1) ||
      ($past(init_phase) == 3'h1 && init_phase == 3'h3))
    else $error("initialization phases out of order");
  a_done_holds: assert property (init_phase == 3'h4 |=> init_phase == 3'h4)
    else $error("normal operation left without reset");
  a_phase3_waits: assert property (init_phase == 3'h3 && !init_done |=> init_phase == 3'h3)
    else $error("phase three left without init_done");
  a_no_wrap: assert property (accel_valid && seen_q |-> step < 11'sd256 && step > -11'sd256)
    else $error("output word jumped as if wrapped");
endmodule
bind accel_dsp_filter_chain accel_dsp_filter_chain_props u_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .sd_bit(sd_bit), .sd_bit_valid(sd_bit_valid),
  .drift_filter_select(drift_filter_select), .selftest_start(selftest_start),
  .selftest_repeats(selftest_repeats), .init_done(init_done),
  .drift_upper_limit(drift_upper_limit), .drift_lower_limit(drift_lower_limit),
  .accel_word(accel_word), .accel_valid(accel_valid),
  .zero_drift_ok_flag(zero_drift_ok_flag), .init_phase(init_phase)
);

// File: test/sd_modulator_model.sv
// Behavioural first-order sigma-delta modulator feeding the filter chain.
`timescale 1ns/10ps
module sd_modulator_model (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [4:0] ones_per16,
  output logic            sd_bit,
  output logic            sd_bit_valid
);
  logic [4:0] tick_q;
  logic [5:0] acc_q;
  logic [5:0] sum;
  logic       hit;
  assign sum = acc_q + {1'b0, ones_per16};
  assign hit = sum >= 6'h10;
  initial begin
    tick_q       = 5'h00;
    acc_q        = 6'h00;
    sd_bit       = 1'b0;
    sd_bit_valid = 1'b0;
  end
  always @(negedge clk) begin
    if (run) begin
      tick_q <= (tick_q == 5'h13) ? 5'h00 : tick_q + 5'h01;
    end
    if (run && tick_q == 5'h00) begin
      sd_bit_valid <= 1'b1;
      sd_bit       <= hit;
      acc_q        <= hit ? sum - 6'h10 : sum;
    end else begin
      sd_bit_valid <= 1'b0;
      // Between bits the line toggles so a stale value is never mistaken for data.
      sd_bit       <= ~sd_bit;
    end
  end
endmodule

// File: test/accel_dsp_filter_chain_tb.sv
// Self-checking bench for the accelerometer filter chain.
`timescale 1ns/10ps
module accel_dsp_filter_chain_tb;
  localparam int SMP = 320;
  logic        clk_sys;
  logic        arst_n;
  logic        sd_bit;
  logic        sd_bit_valid;
  logic        drift_filter_select;
  logic        selftest_start;
  logic [2:0]  selftest_repeats;
  logic        init_done;
  logic [25:0] drift_upper_limit;
  logic [25:0] drift_lower_limit;
  logic [9:0]  accel_word;
  logic        accel_valid;
  logic        zero_drift_ok_flag;
  logic [2:0]  init_phase;
  logic        mod_run;
  logic [4:0]  mod_ones;
  int          miscompares;
  int          num_checks;
  int          cyc;
  int          n;
  // Phase lengths shortened so the whole run stays short.
  accel_dsp_filter_chain #(.DRIFT_COUNT_LIMIT(3), .DRIFT_COUNT_MAX(7), .PH1_LEN(4),
    .PH2_LEN(4), .ST_LEN(4)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .sd_bit(sd_bit), .sd_bit_valid(sd_bit_valid),
    .drift_filter_select(drift_filter_select), .selftest_start(selftest_start),
    .selftest_repeats(selftest_repeats), .init_done(init_done),
    .drift_upper_limit(drift_upper_limit), .drift_lower_limit(drift_lower_limit),
    .accel_word(accel_word), .accel_valid(accel_valid),
    .zero_drift_ok_flag(zero_drift_ok_flag), .init_phase(init_phase));
  sd_modulator_model u_mod (.clk(clk_sys), .run(mod_run), .ones_per16(mod_ones),
    .sd_bit(sd_bit), .sd_bit_valid(sd_bit_valid));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wait_smp(input int k);
    repeat (k * SMP) @(negedge clk_sys);
  endtask
  task automatic start_run(input logic st, input logic [2:0] reps);
    @(negedge clk_sys);
    arst_n = 1'b0;
    mod_run <= 1'b0;
    mod_ones <= 5'h08;
    init_done = 1'b0;
    selftest_start = st;
    selftest_repeats = reps;
    repeat (20) @(negedge clk_sys);
    check(accel_word, 10'h000);
    check(accel_valid, 1'b0);
    check(zero_drift_ok_flag, 1'b1);
    check(init_phase, 3'h0);
    arst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    mod_run <= 1'b1;
  endtask
  // Counts cycles spent in one phase and rounds to whole samples.
  task automatic measure(input logic [2:0] ph, input int exp);
    n = 0;
    while (init_phase === ph && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    check((n + SMP / 2) / SMP, exp);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    arst_n = 1'b0;
    mod_run = 1'b0;
    mod_ones = 5'h08;
    drift_filter_select = 1'b0;
    selftest_start = 1'b0;
    selftest_repeats = 3'h0;
    init_done = 1'b0;
    drift_upper_limit = 26'h1ffffff;
    drift_lower_limit = 26'h2000000;
    start_run(1'b1, 3'h2);
    measure(3'h0, 4);
    measure(3'h1, 4);
    measure(3'h2, 8);
    wait_smp(5);
    check(init_phase, 3'h3);
    init_done = 1'b1;
    n = 0;
    while (init_phase !== 3'h4 && n < 2 * SMP) begin
      @(negedge clk_sys);
      n++;
    end
    check(init_phase, 3'h4);
    n = 0;
    repeat (10 * SMP) begin
      @(negedge clk_sys);
      if (accel_valid === 1'b1) n++;
    end
    check(n, 160);
    wait_smp(8);
    check(zero_drift_ok_flag, 1'b1);
    // Upper below lower puts every estimate outside the window.
    drift_upper_limit = 26'h3ffffff;
    drift_lower_limit = 26'h0000001;
    drift_filter_select = 1'b1;
    mod_ones <= 5'h10;
    wait_smp(2);
    check(zero_drift_ok_flag, 1'b1);
    wait_smp(6);
    check(zero_drift_ok_flag, 1'b0);
    // Full-scale input drives the word into the clip at the largest acceleration code.
    wait_smp(30);
    check(accel_word, 10'h1e0);
    start_run(1'b1, 3'h7);
    measure(3'h0, 4);
    measure(3'h1, 4);
    measure(3'h2, 24);
    start_run(1'b0, 3'h2);
    measure(3'h0, 4);
    measure(3'h1, 4);
    check(init_phase, 3'h3);
    tally_and_finish();
  end
endmodule
